// [rtl/dswr_pkg.sv]
// Package of constants and carrier types for the DAC serial word receiver.
package dswr_pkg;

  // ---------------------------------------------------------------
  // Word and framing
  // ---------------------------------------------------------------
  localparam int unsigned WORD_W = 16;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [4:0] CELL_CLKS = 5'h10;
  localparam logic [4:0] MID_CELL = 5'h08;
  localparam logic [4:0] DATA_CELLS = 5'h10;
  localparam logic [4:0] STOP_CELL = 5'h11;
  localparam logic [3:0] SUB_RST = 4'h0;
  localparam logic [4:0] CELL_RST = 5'h00;

  // ---------------------------------------------------------------
  // Asynchronous receiver states
  // ---------------------------------------------------------------
  typedef enum logic [1:0]
  {
    DSWR_IDLE = 2'b01,
    DSWR_FRAME = 2'b10
  } dswr_state_t;

  // Synchronised pin levels.
  typedef struct packed
  {
    logic sclk;
    logic sdata;
    logic latch;
    logic fault;
  } dswr_pins_t;

  // Word handed to the converter core.
  typedef struct packed
  {
    logic [15:0] code;
    logic strobe;
  } dswr_word_t;

endpackage : dswr_pkg

// [rtl/dswr_receiver.sv]
// Serial word receiver of a current-loop DAC, 3-wire and asynchronous modes.
// Summary of operation
// - Async word framed by start zero, stop one.
// - Async sampling at middle of each data and stop cell.
// - Cells are sixteen clocks, start after falling edge.
// - Top bit at clock 24, then every 16.
// - Stop bit received updates converter word.
// - Bad stop bit gives one-clock data-out pulse.
// - Framing error discards word, value unchanged.
// - 3-wire shifts on clock, latch loads converter.
// - Latch held high selects asynchronous mode.
// - Fault output active low, open drain.
// - Shift one bit per rising serial clock.
// - Data-out shows bit leaving 16-bit register.
`timescale 1ns/1ps

module dswr_receiver
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial pins from the host
  input wire logic sclk_pin,
  input wire logic sdata_pin,
  input wire logic latch_pin,
  // Serial data out pin
  output logic sdata_out,
  // Loop fault sense from the output stage, active high
  input wire logic loop_fault,
  // Open-drain fault pin, driven low while a fault stands
  output logic fault_n_o,
  output logic fault_n_oe,
  // Converter word
  output logic [15:0] dac_code,
  output logic dac_update,
  output logic async_mode
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  // A level counts only once stages two and three agree, which also
  // rejects single-cycle glitches on slow optocoupler edges.
  dswr_pkg::dswr_pins_t s1_r;
  dswr_pkg::dswr_pins_t s2_r;
  dswr_pkg::dswr_pins_t s3_r;
  dswr_pkg::dswr_pins_t pin_r;
  dswr_pkg::dswr_pins_t raw;

  assign raw = '{sclk: sclk_pin, sdata: sdata_pin, latch: latch_pin,
                 fault: loop_fault};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s1_r <= '{sclk: 1'b0, sdata: 1'b1, latch: 1'b0, fault: 1'b0};
    else
      s1_r <= raw;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s2_r <= '{sclk: 1'b0, sdata: 1'b1, latch: 1'b0, fault: 1'b0};
    else
      s2_r <= s1_r;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s3_r <= '{sclk: 1'b0, sdata: 1'b1, latch: 1'b0, fault: 1'b0};
    else
      s3_r <= s2_r;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_agree
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          pin_r[gi] <= (gi == 2);
        else if (s2_r[gi] == s3_r[gi])
          pin_r[gi] <= s2_r[gi];
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Edge detection and mode
  // ---------------------------------------------------------------
  logic sclk_d_r;
  logic latch_d_r;
  logic sdata_d_r;
  logic sclk_rise;
  logic latch_rise;
  logic sdata_fall;
  logic mode_async;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sclk_d_r <= 1'b0;
    else
      sclk_d_r <= pin_r.sclk;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      latch_d_r <= 1'b0;
    else
      latch_d_r <= pin_r.latch;
  end

  // Resets to the idle-high level so no false start follows reset.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sdata_d_r <= 1'b1;
    else
      sdata_d_r <= pin_r.sdata;
  end

  assign sclk_rise = pin_r.sclk & ~sclk_d_r;
  assign latch_rise = pin_r.latch & ~latch_d_r;
  assign sdata_fall = ~pin_r.sdata & sdata_d_r;
  // Latch held high through a pull-up selects the asynchronous mode.
  assign mode_async = pin_r.latch;

  // ---------------------------------------------------------------
  // Three-wire shift register
  // ---------------------------------------------------------------
  // The register shifts only in 3-wire mode, on each rising clock; the
  // host is expected to keep the latch low while shifting.
  logic [15:0] shift_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      shift_r <= dswr_pkg::WORD_RST;
    else if (!mode_async && sclk_rise)
      shift_r <= {shift_r[14:0], pin_r.sdata};
  end

  // ---------------------------------------------------------------
  // Asynchronous receiver
  // ---------------------------------------------------------------
  dswr_pkg::dswr_state_t state_r;
  logic [3:0] sub_r;
  logic [4:0] cell_r;
  logic [15:0] rx_r;
  logic mid_tick;
  logic stop_tick;

  // Counting starts at the first clock edge after the falling edge, so
  // the middle of cell n lands on clock 16n+8 of the frame.
  assign mid_tick = (state_r == dswr_pkg::DSWR_FRAME) && sclk_rise &&
                    ({1'b0, sub_r} == dswr_pkg::MID_CELL - 5'h01);
  assign stop_tick = mid_tick && (cell_r == dswr_pkg::STOP_CELL);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_r <= dswr_pkg::DSWR_IDLE;
    else
    begin
      unique case (state_r)
        dswr_pkg::DSWR_IDLE:
        begin
          // Idle line sits high between words.
          if (mode_async && sdata_fall)
            state_r <= dswr_pkg::DSWR_FRAME;
        end
        dswr_pkg::DSWR_FRAME:
        begin
          // Leaving the asynchronous mode abandons the word in flight.
          if (!mode_async || stop_tick)
            state_r <= dswr_pkg::DSWR_IDLE;
        end
        default:
          state_r <= dswr_pkg::DSWR_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Frame counters
  // ---------------------------------------------------------------
  // Held at zero while idle, so a frame always starts from cell zero.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sub_r <= dswr_pkg::SUB_RST;
      cell_r <= dswr_pkg::CELL_RST;
    end
    else if (state_r == dswr_pkg::DSWR_IDLE)
    begin
      sub_r <= dswr_pkg::SUB_RST;
      cell_r <= dswr_pkg::CELL_RST;
    end
    else if (sclk_rise)
    begin
      sub_r <= sub_r + 4'h1;
      if (sub_r == 4'hf)
        cell_r <= cell_r + 5'h01;
    end
  end

  // ---------------------------------------------------------------
  // Data capture
  // ---------------------------------------------------------------
  // Data cells 1..16 carry the word, top bit first.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rx_r <= dswr_pkg::WORD_RST;
    else if (mid_tick && cell_r != dswr_pkg::CELL_RST &&
             cell_r <= dswr_pkg::DATA_CELLS)
      rx_r <= {rx_r[14:0], pin_r.sdata};
  end

  // ---------------------------------------------------------------
  // Converter word and data-out
  // ---------------------------------------------------------------
  dswr_pkg::dswr_word_t word_r;
  logic sdo_r;
  logic load_async;
  logic load_3w;
  logic bad_stop;

  // ---------------------------------------------------------------
  // Load selection
  // ---------------------------------------------------------------
  // The mode follows the latch level, so at the strobe edge the mode
  // already reads as asynchronous; the edge alone marks a 3-wire load.
  assign load_3w = latch_rise && (state_r == dswr_pkg::DSWR_IDLE);
  assign load_async = stop_tick && pin_r.sdata;
  assign bad_stop = stop_tick && !pin_r.sdata;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      word_r <= '{code: dswr_pkg::WORD_RST, strobe: 1'b0};
    else if (load_async)
      word_r <= '{code: rx_r, strobe: 1'b1};
    else if (load_3w)
      word_r <= '{code: shift_r, strobe: 1'b1};
    else
      word_r.strobe <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sdo_r <= 1'b0;
    else if (mode_async)
      sdo_r <= bad_stop;
    else
      sdo_r <= shift_r[15];
  end

  // ---------------------------------------------------------------
  // Fault pin and outputs
  // ---------------------------------------------------------------
  // Open drain: only ever pulls low, so several devices share a pull-up.
  logic fault_oe_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      fault_oe_r <= 1'b0;
    else
      fault_oe_r <= pin_r.fault;
  end

  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------
  // The fault pin data is always low; only its enable moves.
  logic fault_lvl_r;
  logic mode_out_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      fault_lvl_r <= 1'b0;
    else
      fault_lvl_r <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mode_out_r <= 1'b0;
    else
      mode_out_r <= mode_async;
  end

  assign fault_n_o = fault_lvl_r;
  assign fault_n_oe = fault_oe_r;
  assign sdata_out = sdo_r;
  assign dac_code = word_r.code;
  assign dac_update = word_r.strobe;
  assign async_mode = mode_out_r;

endmodule : dswr_receiver

// [tb/dswr_host.sv]
// Host model driving the serial pins in both modes.
`timescale 1ns/1ps
module dswr_host
(
  // Serial pins
  output logic sclk,
  output logic sdata,
  output logic latch
);
  // The clock stands low outside words, so no stray edge shifts.
  initial
  begin
    sclk = 1'b0;
    sdata = 1'b1;
    latch = 1'b0;
  end
  task automatic tick();
    #200;
    sclk = 1'b1;
    #200;
    sclk = 1'b0;
  endtask : tick
  task automatic shift(input logic [15:0] w);
    latch = 1'b0;
    #400;
    for (int i = 15; i >= 0; i--)
    begin
      sdata = w[i];
      tick();
    end
    sdata = 1'b1;
  endtask : shift
  task automatic strobe();
    #400;
    latch = 1'b1;
    #800;
  endtask : strobe
  task automatic frame(input logic [15:0] w, input logic stop);
    latch = 1'b1;
    #800;
    for (int c = 0; c < 18; c++)
    begin
      sdata = (c == 0) ? 1'b0 : (c == 17) ? stop : w[16 - c];
      repeat (16) tick();
    end
    sdata = 1'b1;
    #800;
  endtask : frame
endmodule : dswr_host

// [tb/dswr_monitor.sv]
// Port checker of the serial word receiver.
`timescale 1ns/1ps
module dswr_monitor
(
  // Receiver ports
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk_pin,
  input wire logic sdata_pin,
  input wire logic latch_pin,
  input wire logic sdata_out,
  input wire logic loop_fault,
  input wire logic fault_n_o,
  input wire logic fault_n_oe,
  input wire logic [15:0] dac_code,
  input wire logic dac_update,
  input wire logic async_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Eight clocks leave room for the pin synchronisers.
  fault_on_a: assert property (loop_fault [*8] |-> fault_n_oe)
    else $error("fault pin not pulled");
  fault_off_a: assert property (!loop_fault [*8] |-> !fault_n_oe)
    else $error("fault pin pulled");
  mode_hi_a: assert property (latch_pin [*8] |-> async_mode)
    else $error("mode not async");
  upd_pulse_a: assert property (dac_update |=> !dac_update)
    else $error("update too long");
  code_hold_a: assert property ($changed(dac_code) |-> dac_update)
    else $error("code moved alone");
  err_pulse_a: assert property (async_mode && sdata_out |=> !sdata_out)
    else $error("error pulse too long");
  err_no_upd_a: assert property (async_mode && sdata_out |-> !dac_update)
    else $error("update on error");
  upd_latch_a: assert property (dac_update |-> latch_pin)
    else $error("update without latch");
endmodule : dswr_monitor

bind dswr_receiver dswr_monitor i_mon (.clk, .rst_n, .sclk_pin, .sdata_pin,
  .latch_pin, .sdata_out, .loop_fault, .fault_n_o, .fault_n_oe, .dac_code,
  .dac_update, .async_mode);

// [tb/dswr_receiver_tb.sv]
// Self-checking bench of the serial word receiver.
`timescale 1ns/1ps
module dswr_receiver_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic loop_fault = 1'b0;
  logic sclk, sdata, latch, sdata_out, fault_n_o, fault_n_oe;
  logic dac_update, async_mode, upd_seen, err_seen;
  logic [15:0] dac_code;
  int miscompares = 0;
  int n_compared = 0;
  always #25 clk = ~clk;
  always @(posedge clk)
  begin
    if (dac_update === 1'b1) upd_seen <= 1'b1;
    if (sdata_out === 1'b1 && async_mode === 1'b1) err_seen <= 1'b1;
  end
  dswr_host i_host (.sclk(sclk), .sdata(sdata), .latch(latch));
  dswr_receiver i_dut (.clk(clk), .rst_n(rst_n), .sclk_pin(sclk),
    .sdata_pin(sdata), .latch_pin(latch), .sdata_out(sdata_out),
    .loop_fault(loop_fault), .fault_n_o(fault_n_o),
    .fault_n_oe(fault_n_oe), .dac_code(dac_code),
    .dac_update(dac_update), .async_mode(async_mode));
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %0t word %h not %h", $time, got, exp);
    end
  endtask : chk16
  task automatic chk1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %0t bit %b not %b", $time, got, exp);
    end
  endtask : chk1
  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task automatic t_fault();
    loop_fault = 1'b1;
    repeat (10) @(negedge clk);
    chk1(fault_n_oe, 1'b1);
    chk1(fault_n_o, 1'b0);
    loop_fault = 1'b0;
    repeat (10) @(negedge clk);
    chk1(fault_n_oe, 1'b0);
  endtask : t_fault
  task automatic t_three_wire();
    i_host.shift(16'ha5c3);
    repeat (8) @(negedge clk);
    chk1(sdata_out, 1'b1);
    chk1(async_mode, 1'b0);
    i_host.shift(16'h0ff1);
    repeat (8) @(negedge clk);
    chk1(sdata_out, 1'b0);
    upd_seen = 1'b0;
    i_host.strobe();
    chk1(upd_seen, 1'b1);
    chk16(dac_code, 16'h0ff1);
  endtask : t_three_wire
  task automatic t_async_good();
    upd_seen = 1'b0;
    err_seen = 1'b0;
    i_host.frame(16'h8001, 1'b1);
    chk1(upd_seen, 1'b1);
    chk1(async_mode, 1'b1);
    chk16(dac_code, 16'h8001);
    i_host.frame(16'h7ffe, 1'b1);
    chk16(dac_code, 16'h7ffe);
    chk1(err_seen, 1'b0);
  endtask : t_async_good
  task automatic t_async_bad();
    upd_seen = 1'b0;
    err_seen = 1'b0;
    i_host.frame(16'h1234, 1'b0);
    chk1(err_seen, 1'b1);
    chk1(upd_seen, 1'b0);
    chk16(dac_code, 16'h7ffe);
  endtask : t_async_bad
  initial
  begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (5) @(negedge clk);
    t_fault();
    t_three_wire();
    t_async_good();
    t_async_bad();
    print_verdict();
  end
  // Three frames take about 350 us; the limit leaves wide margin.
  initial
  begin
    #1000000;
    miscompares++;
    print_verdict();
  end
endmodule : dswr_receiver_tb
